// ### pkg/sfwgbl_defs.svh
// constants for the write guard and block lock logic of a serial flash
// assumes: included by bare name from the package and the design modules
`ifndef SFWGBL_DEFS_SVH
`define SFWGBL_DEFS_SVH

// ----------------------------------------------------------------------
// command opcodes
// ----------------------------------------------------------------------
`define SFWGBL_OP_WREN      8'h06
`define SFWGBL_OP_WRDI      8'h04
`define SFWGBL_OP_VWEN      8'h50
`define SFWGBL_OP_LOCK      8'h36
`define SFWGBL_OP_UNLOCK    8'h39
`define SFWGBL_OP_PROG1     8'h02
`define SFWGBL_OP_PROG2     8'hA2
`define SFWGBL_OP_PROG4     8'h32
`define SFWGBL_OP_SEQA      8'hAF
`define SFWGBL_OP_SEQB      8'hAD
`define SFWGBL_OP_ER4K      8'h20
`define SFWGBL_OP_ER32K     8'h52
`define SFWGBL_OP_ER64K     8'hD8
`define SFWGBL_OP_CHIPA     8'h60
`define SFWGBL_OP_CHIPB     8'hC7
`define SFWGBL_OP_OTP       8'h9B
`define SFWGBL_OP_WRSR1     8'h01
`define SFWGBL_OP_WRSR2     8'h31
`define SFWGBL_OP_WRSR3     8'h11
`define SFWGBL_OP_WRSR4     8'h71

// ----------------------------------------------------------------------
// frame lengths and counters
// ----------------------------------------------------------------------
`define SFWGBL_CNT_ZERO     6'h00
`define SFWGBL_CNT_ONE      6'h01
`define SFWGBL_CNT_MAX      6'h3F
`define SFWGBL_OPC_BITS     6'h08
`define SFWGBL_ADR_BITS     6'h20
`define SFWGBL_PHASE_ZERO   3'h0
`define SFWGBL_PHASE_ONE    3'h1

// ----------------------------------------------------------------------
// block geometry and protection
// ----------------------------------------------------------------------
`define SFWGBL_BLK_LSB      12
`define SFWGBL_BLK_MSB      18
`define SFWGBL_BLK_AW       7
`define SFWGBL_BLK_CNT      128
`define SFWGBL_BLK_TOTAL    8'h80
`define SFWGBL_LOCK_RST     1'b1
`define SFWGBL_BP_NONE      3'h0
`define SFWGBL_BP_ONE       3'h1
`define SFWGBL_BP_SEC_CAP   3'h4
`define SFWGBL_SEC_CAP      8'h08
`define SFWGBL_SEC_BASE     8'h01
`define SFWGBL_BIG_BASE     12'h010
`define SFWGBL_BIG_CAP      12'h080

`endif

// ### pkg/sfwgbl_pkg.sv
// types shared by the write guard and block lock logic
// assumes: the defs header sits beside it on the include path
`include "sfwgbl_defs.svh"

package sfwgbl_pkg;
	// ------------------------------------------------------------------
	// types
	// ------------------------------------------------------------------
	typedef logic [7:0]  sfwgbl_byte_t;
	typedef logic [23:0] sfwgbl_addr_t;
	typedef logic [`SFWGBL_BLK_AW-1:0] sfwgbl_blk_t;
	// gray sequence idle -> look -> decide -> rest -> idle
	typedef enum logic [1:0] {
		st_idle   = 2'b00,
		st_look   = 2'b01,
		st_decide = 2'b11,
		st_rest   = 2'b10
	} sfwgbl_state_t;
endpackage

// ### rtl/sfwgbl_lock_mem.sv
// per-block lock bits with one write port and a registered read port
// assumes: single clock, asynchronous active-low reset sets every bit
`timescale 1ns/10ps
`include "sfwgbl_defs.svh"

module sfwgbl_lock_mem #(
	parameter int DEPTH = `SFWGBL_BLK_CNT,
	parameter int AW    = `SFWGBL_BLK_AW
) (
	input  wire logic          clk,
	input  wire logic          arst_n,
	input  wire logic          wr_en,
	input  wire logic [AW-1:0] wr_addr,
	input  wire logic          wr_data,
	input  wire logic [AW-1:0] rd_addr,
	output logic               rd_data
);
	logic [DEPTH-1:0] bits;

	// ------------------------------------------------------------------
	// storage: one flop per block, all locked out of reset
	// ------------------------------------------------------------------
	for (genvar i = 0; i < DEPTH; i++) begin : g_bit
		wire logic hit = wr_en && (wr_addr == AW'(i));
		always_ff @(posedge clk or negedge arst_n) begin
			if (!arst_n) begin
				bits[i] <= `SFWGBL_LOCK_RST;
			end else if (hit) begin
				bits[i] <= wr_data;
			end
		end
	end

	// registered read keeps the lookup off the decision path
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			rd_data <= `SFWGBL_LOCK_RST;
		end else begin
			rd_data <= bits[rd_addr];
		end
	end
endmodule

// ### rtl/sfwgbl_top.sv
// write-enable latch, volatile status arming and per-block lock handling
// assumes: host drives sck/cs_n/si (mode 0), holds cs_n high >= 5 clk;
// protection field inputs and wel_clear_req come from logic on clk
`timescale 1ns/10ps
`include "sfwgbl_defs.svh"

module sfwgbl_top (
	input  wire logic                clk,
	input  wire logic                arst_n,
	input  wire logic                sck,
	input  wire logic                cs_n,
	input  wire logic                si,
	input  wire logic                lock_scheme_select,
	input  wire logic                protect_invert,
	input  wire logic                protect_granule_size,
	input  wire logic                protect_top_bottom,
	input  wire logic [2:0]          protect_range_field,
	input  wire logic                wel_clear_req,
	output logic                     write_enable_latch,
	output logic                     volatile_armed,
	output logic                     exec_valid,
	output logic                     exec_refused,
	output logic                     exec_volatile,
	output sfwgbl_pkg::sfwgbl_byte_t exec_op,
	output sfwgbl_pkg::sfwgbl_addr_t exec_addr
);
	import sfwgbl_pkg::*;

	// ------------------------------------------------------------------
	// link side, clocked by sck
	// ------------------------------------------------------------------
	logic [22:0] shreg;
	sfwgbl_byte_t op_hold;
	sfwgbl_addr_t adr_hold;
	logic [5:0]  bit_cnt;
	logic [5:0]  res_cnt;
	logic [2:0]  res_phase;
	logic        frame_tgl;
	wire logic   link_rst_n = arst_n & ~cs_n;
	wire logic [5:0] next_cnt = (bit_cnt == `SFWGBL_CNT_MAX) ?
		bit_cnt : bit_cnt + `SFWGBL_CNT_ONE;

	// per-frame bit counter, cleared whenever the chip is deselected
	always_ff @(posedge sck or negedge link_rst_n) begin
		if (!link_rst_n) begin
			bit_cnt <= `SFWGBL_CNT_ZERO;
		end else begin
			bit_cnt <= next_cnt;
		end
	end

	// frame results survive deselect so the clk side can read them
	always_ff @(posedge sck or negedge arst_n) begin
		if (!arst_n) begin
			shreg     <= 23'h00_0000;
			op_hold   <= 8'h00;
			adr_hold  <= 24'h00_0000;
			res_cnt   <= `SFWGBL_CNT_ZERO;
			res_phase <= `SFWGBL_PHASE_ZERO;
			frame_tgl <= 1'b0;
		end else begin
			shreg   <= {shreg[21:0], si};
			res_cnt <= next_cnt;
			// opcode then address kept apart, msb first
			if (next_cnt == `SFWGBL_OPC_BITS) begin
				op_hold <= {shreg[6:0], si};
			end
			if (next_cnt == `SFWGBL_ADR_BITS) begin
				adr_hold <= {shreg[22:0], si};
			end
			if (bit_cnt == `SFWGBL_CNT_ZERO) begin
				frame_tgl <= ~frame_tgl;
				res_phase <= `SFWGBL_PHASE_ONE;
			end else begin
				res_phase <= res_phase + `SFWGBL_PHASE_ONE;
			end
		end
	end

	// ------------------------------------------------------------------
	// crossing into clk: deselect and frame marker via two flops each
	// ------------------------------------------------------------------
	logic cs_meta;
	logic cs_sync;
	logic cs_prev;
	logic tgl_meta;
	logic tgl_sync;
	logic tgl_seen;

	// link results stand still while cs_n is high, so they are read as-is
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			cs_meta  <= 1'b1;
			cs_sync  <= 1'b1;
			cs_prev  <= 1'b1;
			tgl_meta <= 1'b0;
			tgl_sync <= 1'b0;
		end else begin
			cs_meta  <= cs_n;
			cs_sync  <= cs_meta;
			cs_prev  <= cs_sync;
			tgl_meta <= frame_tgl;
			tgl_sync <= tgl_meta;
		end
	end

	wire logic commit = cs_sync & ~cs_prev;

	// ------------------------------------------------------------------
	// capture of the finished frame
	// ------------------------------------------------------------------
	sfwgbl_state_t state;
	sfwgbl_state_t next_state;
	sfwgbl_byte_t  cap_op;
	sfwgbl_addr_t  cap_addr;
	logic [5:0]    cap_cnt;
	logic          cap_aligned;
	logic          cap_fresh;

	// an sck-less frame leaves the marker unchanged and is ignored
	// byte boundary check
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			cap_op      <= 8'h00;
			cap_addr    <= 24'h00_0000;
			cap_cnt     <= `SFWGBL_CNT_ZERO;
			cap_aligned <= 1'b0;
			cap_fresh   <= 1'b0;
			tgl_seen    <= 1'b0;
		end else if (commit) begin
			cap_op      <= op_hold;
			cap_addr    <= adr_hold;
			cap_cnt     <= res_cnt;
			cap_aligned <= (res_phase == `SFWGBL_PHASE_ZERO);
			cap_fresh   <= (tgl_sync != tgl_seen);
			tgl_seen    <= tgl_sync;
		end
	end

	// ------------------------------------------------------------------
	// command decode
	// ------------------------------------------------------------------
	wire logic frame_ok = cap_fresh & cap_aligned &
		(cap_cnt >= `SFWGBL_OPC_BITS);
	// opcode-only frames must be exactly one byte
	wire logic len_opc  = frame_ok & (cap_cnt == `SFWGBL_OPC_BITS);
	// lock frames carry no data phase
	wire logic len_adr  = frame_ok & (cap_cnt == `SFWGBL_ADR_BITS);
	wire logic has_adr  = frame_ok & (cap_cnt >= `SFWGBL_ADR_BITS);

	wire logic is_wren   = len_opc & (cap_op == `SFWGBL_OP_WREN);
	wire logic is_wrdi   = len_opc & (cap_op == `SFWGBL_OP_WRDI);
	wire logic is_vwen   = len_opc & (cap_op == `SFWGBL_OP_VWEN);
	wire logic is_lock   = len_adr & (cap_op == `SFWGBL_OP_LOCK);
	wire logic is_unlock = len_adr & (cap_op == `SFWGBL_OP_UNLOCK);

	wire logic op_prog = (cap_op == `SFWGBL_OP_PROG1) |
		(cap_op == `SFWGBL_OP_PROG2) | (cap_op == `SFWGBL_OP_PROG4) |
		(cap_op == `SFWGBL_OP_SEQA)  | (cap_op == `SFWGBL_OP_SEQB);
	wire logic op_erase = (cap_op == `SFWGBL_OP_ER4K) |
		(cap_op == `SFWGBL_OP_ER32K) | (cap_op == `SFWGBL_OP_ER64K);
	wire logic op_chip = (cap_op == `SFWGBL_OP_CHIPA) |
		(cap_op == `SFWGBL_OP_CHIPB);
	wire logic op_wrsr1 = (cap_op == `SFWGBL_OP_WRSR1);
	wire logic op_wrsr = op_wrsr1 | (cap_op == `SFWGBL_OP_WRSR2) |
		(cap_op == `SFWGBL_OP_WRSR3) | (cap_op == `SFWGBL_OP_WRSR4);
	wire logic op_otp  = (cap_op == `SFWGBL_OP_OTP);

	// addressed array writes need the full address before they count
	wire logic need_prot = op_prog | op_erase;
	wire logic guarded   = need_prot ? has_adr :
		(frame_ok & (op_chip | op_wrsr | op_otp));

	// ------------------------------------------------------------------
	// protection lookup
	// ------------------------------------------------------------------
	logic        lock_bit;
	wire logic   lock_wr = (state == st_decide) &
		(is_lock | is_unlock) & write_enable_latch;
	// one bit per aligned 4 kB region
	wire sfwgbl_blk_t blk =
		cap_addr[`SFWGBL_BLK_MSB:`SFWGBL_BLK_LSB];

	// reset-locked bits lock or unlock write
	sfwgbl_lock_mem #(
		.DEPTH (`SFWGBL_BLK_CNT),
		.AW    (`SFWGBL_BLK_AW)
	) u_lock_mem (
		.clk     (clk),
		.arst_n  (arst_n),
		.wr_en   (lock_wr),
		.wr_addr (blk),
		.wr_data (is_lock),
		.rd_addr (blk),
		.rd_data (lock_bit)
	);

	// range scheme: blocks counted from top or bottom, optionally inverted
	wire logic [2:0]  bp_m1   = protect_range_field - `SFWGBL_BP_ONE;
	wire logic [7:0]  n_sec   = (protect_range_field >= `SFWGBL_BP_SEC_CAP) ?
		`SFWGBL_SEC_CAP : (`SFWGBL_SEC_BASE << bp_m1);
	wire logic [11:0] n_big_w = `SFWGBL_BIG_BASE << bp_m1;
	wire logic [7:0]  n_big   = (n_big_w > `SFWGBL_BIG_CAP) ?
		`SFWGBL_BLK_TOTAL : n_big_w[7:0];
	wire logic [7:0]  n_blk   = (protect_range_field == `SFWGBL_BP_NONE) ?
		8'h00 : (protect_granule_size ? n_sec : n_big);
	wire logic [7:0]  blk8    = {1'b0, blk};
	wire logic in_zone = protect_top_bottom ? (blk8 < n_blk) :
		(blk8 >= (`SFWGBL_BLK_TOTAL - n_blk));
	wire logic range_prot = in_zone ^ protect_invert;

	// scheme select picks block bits or the range fields
	// locked block blocks program and erase
	wire logic prot = need_prot &
		(lock_scheme_select ? lock_bit : range_prot);
	// armed status write reaches volatile bits without the latch
	wire logic vol_path = op_wrsr1 & volatile_armed;
	// latch gate on every write-type command but the armed volatile status write
	wire logic grant = guarded & ~prot & (vol_path | write_enable_latch);

	// ------------------------------------------------------------------
	// sequencer: lookup has one cycle of read latency
	// ------------------------------------------------------------------
	always_comb begin
		next_state = state;
		case (state)
			st_idle: begin
				if (commit) begin
					next_state = st_look;
				end
			end
			st_look: begin
				next_state = st_decide;
			end
			st_decide: begin
				next_state = st_rest;
			end
			default: begin
				next_state = st_idle;
			end
		endcase
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			state <= st_idle;
		end else begin
			state <= next_state;
		end
	end

	// ------------------------------------------------------------------
	// latch and arming updates
	// ------------------------------------------------------------------
	wire logic decide = (state == st_decide);
	logic next_wel;
	logic next_armed;

	// later assignments win, so a set beats any clear in the same cycle
	always_comb begin
		next_wel = write_enable_latch;
		if (wel_clear_req) begin
			next_wel = 1'b0;
		end
		if (decide && is_wrdi) begin
			next_wel = 1'b0;
		end
		// an accepted lock or unlock clears the latch
		if (lock_wr) begin
			next_wel = 1'b0;
		end
		if (decide && is_wren) begin
			next_wel = 1'b1;
		end
	end

	// arm on volatile enable, disarm on any other valid command
	always_comb begin
		next_armed = volatile_armed;
		if (decide && frame_ok) begin
			next_armed = is_vwen;
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			write_enable_latch <= 1'b0;
			volatile_armed     <= 1'b0;
		end else begin
			write_enable_latch <= next_wel;
			volatile_armed     <= next_armed;
		end
	end

	// ------------------------------------------------------------------
	// execution grant towards the program/erase/status engines
	// ------------------------------------------------------------------
	// one-cycle pulses, op and address held until the next guarded decision
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			exec_valid    <= 1'b0;
			exec_refused  <= 1'b0;
			exec_volatile <= 1'b0;
			exec_op       <= 8'h00;
			exec_addr     <= 24'h00_0000;
		end else begin
			exec_valid    <= decide & grant;
			exec_refused  <= decide & guarded & ~grant;
			exec_volatile <= decide & grant & vol_path;
			if (decide && guarded) begin
				exec_op   <= cap_op;
				exec_addr <= cap_addr;
			end
		end
	end
endmodule

// ### bench/sfwgbl_host.sv
// host model: drives chip select, serial clock and serial data, mode 0
// assumes: the bench calls frame() and leaves 12 clk periods (at least 1100 ns) between frames
`timescale 1ns/10ps

module sfwgbl_host (
	output logic sck,
	output logic cs_n,
	output logic si
);
	// ------------------
	// frame driver
	// ------------------
	// msb first
	// whole bits
	// only a scenario about aborts passes a count off a byte boundary;
	// sck runs at 6 ns inside the frame and stands low outside it
	task automatic frame(input logic [39:0] bits, input int n);
		cs_n = 1'b0;
		for (int i = 0; i < n; i++) begin
			#2 si = bits[39-i];
			#1 sck = 1'b1;
			#3 sck = 1'b0;
		end
		// released data line shows no stale value
		#2 si = ~si;
		#1 cs_n = 1'b1;
	endtask

	initial begin
		sck = 1'b0;
		cs_n = 1'b1;
		si = 1'b0;
	end
endmodule

// ### bench/sfwgbl_top_monitor.sv
// checker for the write guard top, bound onto its ports
// assumes: outputs move on clk; cs_n is sampled here as a plain level
`timescale 1ns/10ps
`include "sfwgbl_defs.svh"

module sfwgbl_top_monitor (
	input logic                     clk,
	input logic                     arst_n,
	input logic                     cs_n,
	input logic                     wel_clear_req,
	input logic                     write_enable_latch,
	input logic                     volatile_armed,
	input logic                     exec_valid,
	input logic                     exec_refused,
	input logic                     exec_volatile,
	input sfwgbl_pkg::sfwgbl_byte_t exec_op
);
	import sfwgbl_pkg::*;
	logic [3:0] idle_cnt;
	logic [3:0] next_idle_cnt;

	// saturating idle count: after 8 idle cycles no commit is pending
	assign next_idle_cnt = !cs_n ? 4'h0 :
		(idle_cnt == 4'hF) ? idle_cnt : idle_cnt + 4'h1;
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n)
			idle_cnt <= 4'h0;
		else
			idle_cnt <= next_idle_cnt;
	end

	default clocking @(posedge clk); endclocking
	default disable iff (!arst_n);

	pulse_exclusive_a: assert property (
		exec_valid |-> !exec_refused) else $error("grant with refuse");
	grant_needs_latch_a: assert property (
		exec_valid && !exec_volatile |-> $past(write_enable_latch))
		else $error("grant without latch");
	volatile_grant_a: assert property (
		exec_volatile |-> exec_valid && $past(volatile_armed) &&
		exec_op == `SFWGBL_OP_WRSR1) else $error("bad volatile grant");
	pulse_single_a: assert property (
		exec_valid || exec_refused |=> !exec_valid && !exec_refused)
		else $error("pulse longer than one cycle");
	latch_set_commit_a: assert property (
		$rose(write_enable_latch) |-> $past(cs_n, 3) && !exec_valid &&
		!exec_refused) else $error("latch set outside commit");
	latch_clear_cause_a: assert property (
		$fell(write_enable_latch) |-> $past(cs_n, 3) ||
		$past(wel_clear_req)) else $error("latch cleared unasked");
	arm_keeps_latch_a: assert property (
		$rose(volatile_armed) && !$past(wel_clear_req) |->
		$stable(write_enable_latch) && $past(cs_n, 3))
		else $error("arming moved the latch");
	clear_request_a: assert property (
		wel_clear_req && idle_cnt >= 4'h8 |=> !write_enable_latch)
		else $error("clear request ignored");
	opcode_held_a: assert property (
		!exec_valid && !exec_refused |-> $stable(exec_op))
		else $error("opcode changed without pulse");
endmodule

bind sfwgbl_top sfwgbl_top_monitor i_mon (
	.clk               (clk),
	.arst_n            (arst_n),
	.cs_n              (cs_n),
	.wel_clear_req     (wel_clear_req),
	.write_enable_latch(write_enable_latch),
	.volatile_armed    (volatile_armed),
	.exec_valid        (exec_valid),
	.exec_refused      (exec_refused),
	.exec_volatile     (exec_volatile),
	.exec_op           (exec_op)
);

// ### bench/tb.sv
// self-checking bench for the write guard and block lock top
// assumes: host model and bound checker compiled beforehand
`timescale 1ns/10ps

module tb;
	import sfwgbl_pkg::*;
	// expect bits: volatile, grant, refuse, latch after, armed after
	typedef struct {
		sfwgbl_byte_t op;
		sfwgbl_addr_t addr;
		int           n;
		logic [4:0]   exp;
	} sfwgbl_row_t;
	logic clk, arst_n, sck, cs_n, si, wel_clear_req;
	logic lock_scheme_select, protect_invert, protect_granule_size;
	logic protect_top_bottom, write_enable_latch, volatile_armed;
	logic exec_valid, exec_refused, exec_volatile, seen_v, seen_r, seen_vol;
	logic [2:0] protect_range_field;
	sfwgbl_byte_t exec_op;
	sfwgbl_addr_t exec_addr;
	int num_errors, samples_checked, cycles;
	sfwgbl_row_t rows [33] = '{
		'{8'h02,24'h001000,40,5'b00100}, '{8'hA2,24'h001000,40,5'b00100},
		'{8'h32,24'h001000,40,5'b00100}, '{8'hAF,24'h001000,40,5'b00100},
		'{8'hAD,24'h001000,40,5'b00100}, '{8'h20,24'h001000,32,5'b00100},
		'{8'h52,24'h001000,32,5'b00100}, '{8'hD8,24'h001000,32,5'b00100},
		'{8'h60,24'h000000,8,5'b00100}, '{8'hC7,24'h000000,8,5'b00100},
		'{8'h9B,24'h000100,40,5'b00100}, '{8'h01,24'h000000,16,5'b00100},
		'{8'h31,24'h000000,16,5'b00100}, '{8'h11,24'h000000,16,5'b00100},
		'{8'h71,24'h000000,16,5'b00100},
		'{8'h36,24'h001000,32,5'b00000}, '{8'h06,24'h000000,8,5'b00010},
		'{8'h20,24'h001000,32,5'b00110}, '{8'h39,24'h001234,32,5'b00000},
		'{8'h06,24'h000000,8,5'b00010}, '{8'h20,24'h001FFF,32,5'b01010},
		'{8'h20,24'h002000,32,5'b00110}, '{8'h36,24'h001ABC,32,5'b00000},
		'{8'h06,24'h000000,8,5'b00010}, '{8'h20,24'h001000,32,5'b00110},
		'{8'h04,24'h000000,8,5'b00000}, '{8'h50,24'h000000,8,5'b00001},
		'{8'h01,24'h000000,16,5'b11000}, '{8'h01,24'h000000,16,5'b00100},
		'{8'h06,24'h000000,9,5'b00000}, '{8'h06,24'h000000,8,5'b00010},
		'{8'h04,24'h000000,7,5'b00010}, '{8'h04,24'h000000,16,5'b00010}};

	sfwgbl_top i_sfwgbl_top (.clk(clk), .arst_n(arst_n), .sck(sck),
		.cs_n(cs_n), .si(si), .lock_scheme_select(lock_scheme_select),
		.protect_invert(protect_invert),
		.protect_granule_size(protect_granule_size),
		.protect_top_bottom(protect_top_bottom),
		.protect_range_field(protect_range_field),
		.wel_clear_req(wel_clear_req),
		.write_enable_latch(write_enable_latch),
		.volatile_armed(volatile_armed), .exec_valid(exec_valid),
		.exec_refused(exec_refused), .exec_volatile(exec_volatile),
		.exec_op(exec_op), .exec_addr(exec_addr));
	sfwgbl_host i_sfwgbl_host (.sck(sck), .cs_n(cs_n), .si(si));

	task automatic give_verdict();
		if (num_errors == 0 && samples_checked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task automatic chk(input logic got, input logic want, input string m);
		samples_checked++;
		if (got !== want) begin
			num_errors++;
			$display("[ERR] %0t ns: %s", $time, m);
		end
	endtask
	task automatic chk_rst();
		chk(write_enable_latch, 1'b0, "latch after reset");
		chk(volatile_armed, 1'b0, "arm after reset");
		chk(exec_op === 8'h00 && exec_addr === 24'h0, 1'b1, "held regs");
	endtask
	// one frame, then a wait long enough for the commit to land
	task automatic run(input sfwgbl_row_t r);
		seen_v = 1'b0;
		seen_r = 1'b0;
		seen_vol = 1'b0;
		i_sfwgbl_host.frame({r.op, r.addr, 8'h00}, r.n);
		repeat (12) @(negedge clk);
		chk(seen_vol, r.exp[4], "volatile pulse");
		chk(seen_v, r.exp[3], "grant pulse");
		chk(seen_r, r.exp[2], "refuse pulse");
		chk(write_enable_latch, r.exp[1], "latch");
		chk(volatile_armed, r.exp[0], "volatile arm");
		if (r.exp[3] | r.exp[2]) begin
			chk(exec_op === r.op, 1'b1, "opcode");
			if (r.n >= 32)
				chk(exec_addr === r.addr, 1'b1, "address");
		end
	endtask

	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	// pulses last one cycle, so they are caught as they pass
	always @(posedge clk) begin
		seen_v <= seen_v | (exec_valid === 1'b1);
		seen_r <= seen_r | (exec_refused === 1'b1);
		seen_vol <= seen_vol | (exec_volatile === 1'b1);
		cycles <= cycles + 1;
		if (cycles == 2000) begin
			num_errors++;
			give_verdict();
		end
	end

	initial begin
		arst_n = 1'b0;
		wel_clear_req = 1'b0;
		lock_scheme_select = 1'b1;
		protect_invert = 1'b0;
		protect_granule_size = 1'b0;
		protect_top_bottom = 1'b0;
		protect_range_field = 3'h0;
		repeat (12) @(negedge clk);
		arst_n = 1'b1;
		@(negedge clk);
		chk_rst();
		foreach (rows[i]) run(rows[i]);
		// range fields govern with scheme select low
		lock_scheme_select = 1'b0;
		run('{8'h20, 24'h003000, 32, 5'b01010});
		protect_invert = 1'b1;
		run('{8'h20, 24'h003000, 32, 5'b00110});
		// range fields: one 4 kB block at the bottom, then 64 kB at the top
		protect_invert = 1'b0;
		protect_granule_size = 1'b1;
		protect_top_bottom = 1'b1;
		protect_range_field = 3'h1;
		run('{8'h20, 24'h000000, 32, 5'b00110});
		run('{8'h20, 24'h001000, 32, 5'b01010});
		protect_granule_size = 1'b0;
		protect_top_bottom = 1'b0;
		run('{8'h20, 24'h070000, 32, 5'b00110});
		run('{8'h20, 24'h06F000, 32, 5'b01010});
		wel_clear_req = 1'b1;
		@(negedge clk);
		wel_clear_req = 1'b0;
		@(negedge clk);
		chk(write_enable_latch, 1'b0, "clear request");
		// second reset locks an unlocked block again
		protect_invert = 1'b0;
		lock_scheme_select = 1'b1;
		run('{8'h06, 24'h0, 8, 5'b00010});
		run('{8'h39, 24'h004000, 32, 5'b00000});
		run('{8'h06, 24'h0, 8, 5'b00010});
		run('{8'h02, 24'h004010, 40, 5'b01010});
		arst_n = 1'b0;
		repeat (3) @(negedge clk);
		arst_n = 1'b1;
		@(negedge clk);
		chk_rst();
		run('{8'h06, 24'h0, 8, 5'b00010});
		run('{8'h02, 24'h004010, 40, 5'b00110});
		give_verdict();
	end
endmodule
